// *** bench/rdr_i2c_host.sv ***
// bench: bus host model that drives the clock line and pulls the data line
`timescale 1ns/100ps
module rdr_i2c_host (
  // clock
  input  wire logic clk_in,
  // bus lines, data line is wired with a pull-up
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // lines idle high, nothing pulled
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // start, also used as repeated start; the target may still hold ack
  task automatic start();
    tick(2);
    sda_oe_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_oe_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_oe_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_oe_out <= 1'b0;
    tick(6);
  endtask

  // data settles 3 clk before the clock rises, held 4 clk high
  task automatic put_bit(input logic b);
    tick(2);
    sda_oe_out <= !b;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask

  task automatic get_bit(output logic b);
    tick(2);
    sda_oe_out <= 1'b0;
    tick(3);
    scl_out <= 1'b1;
    tick(2);
    b = sda_in;
    tick(2);
    scl_out <= 1'b0;
  endtask

  // byte out msb first, then the target's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    ack = !a;
  endtask

  // byte in; the last byte of a read is refused to end it
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask
endmodule // rdr_i2c_host

// *** bench/tb_rdr_ctl.sv ***
// bench: self-checking testbench of the redriver control top
`timescale 1ns/100ps
module tb_rdr_ctl;
  import rdr_pkg::*;
  logic                    clk_in = 1'b0;
  logic                    rst_in = 1'b1;
  logic                    chip_en = 1'b1;
  logic [LVL_W-1:0]        addr_sel = LVL_GND;
  logic [N_PINS*LVL_W-1:0] straps = {7{LVL_PD}};
  logic                    rx_det = 1'b0;
  logic                    lnk_idle = 1'b0;
  logic                    scl, h_oe, d_oe, d_sda, sda_w, lock, chan_en;
  logic                    term_ind, det_en, term_hiz, cm_en, ack_b;
  logic [N_CFG*8-1:0]      cfg;
  logic [N_PINS*LVL_W-1:0] pin_cfg;
  logic [2:0]              pwr;
  logic [31:0]             rd;
  logic [6:0]              dev_adr = ADR_SHORT;
  logic [6:0]              adr_tab [5] = '{ADR_SHORT, ADR_PD, ADR_OPEN,
                                           ADR_PU, ADR_SHORT};
  int                      failures = 0;
  int                      compares = 0;
  int                      cyc = 0;

  // pull-up wired line: low if either side pulls
  assign sda_w = !(h_oe || (d_oe && !d_sda));

  always #12.5 clk_in = ~clk_in;

  rdr_i2c_host host_i (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl),
                       .sda_oe_out(h_oe));

  rdr_ctl rdr_ctl_i (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(d_sda), .sda_oe_out(d_oe), .chip_enable_pin_in(chip_en),
    .addr_sel_pin_in(addr_sel),
    .chan_a_equalizer_pin_in(straps[2:0]),
    .chan_b_equalizer_pin_in(straps[5:3]),
    .chan_a_deemphasis_pin_in(straps[8:6]),
    .chan_b_deemphasis_pin_in(straps[11:9]),
    .chan_a_swing_pin_in(straps[14:12]),
    .chan_b_swing_pin_in(straps[17:15]),
    .squelch_threshold_pin_in(straps[20:18]),
    .rx_det_in(rx_det), .lnk_idle_in(lnk_idle), .cfg_regs_out(cfg),
    .pin_cfg_out(pin_cfg), .lock_open_out(lock), .pwr_state_out(pwr),
    .chan_en_out(chan_en), .term_ind_out(term_ind), .det_en_out(det_en),
    .term_hiz_out(term_hiz), .cm_en_out(cm_en));

  task automatic report_and_stop();
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // cycle ceiling well above the longest expected run
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // waits 1 ns so that outputs updated at the edge have landed
  // wide enough for the whole register image plus the lock flag
  task automatic check(input logic [64:0] seen, input logic [64:0] exp);
    #1;
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] ofs, input logic [31:0] d,
                        input int n);
    logic a, ok;
    host_i.start();
    host_i.wbyte({dev_adr, 1'b0}, ok);
    host_i.wbyte(ofs, a);
    ok &= a;
    for (int k = 0; k < n; k++) begin
      host_i.wbyte(d[8*k +: 8], a);
      ok &= a;
    end
    host_i.stop();
    check(ok, 1'b1);
  endtask

  task automatic reg_rd(input logic [7:0] ofs, input int n,
                        output logic [31:0] d);
    logic       a;
    logic [7:0] b;
    d = 32'h0;
    host_i.start();
    host_i.wbyte({dev_adr, 1'b0}, a);
    host_i.wbyte(ofs, a);
    host_i.stop();
    host_i.start();
    host_i.wbyte({dev_adr, 1'b1}, a);
    for (int k = 0; k < n; k++) begin
      host_i.rbyte(b, k == n - 1);
      d[8*k +: 8] = b;
    end
    host_i.stop();
  endtask

  // enable low, deep state seen, enable high again
  task automatic pulse_enable();
    tick(1);
    chip_en <= 1'b0;
    tick(4);
    check({pwr, chan_en, term_hiz, cm_en}, {3'h1, 3'h2});
    tick(1);
    chip_en <= 1'b1;
    tick(4);
  endtask

  // sampled on the falling edge, the pulse lasts one cycle only
  task automatic wait_poll();
    int i;
    i = 0;
    while (det_en !== 1'b1 && i < 4100) begin
      @(negedge clk_in);
      i++;
    end
    check(det_en, 1'b1);
    tick(2);
  endtask

  initial begin
    tick(2);
    rst_in <= 1'b0;
    // release reset fires one internal reset, so active settles at edge 4
    tick(4);
    check({cfg, lock}, 65'h0);
    check({pwr, term_ind}, {3'h4, 1'b1});
    check(pin_cfg, {7{LVL_PD}});
    // every address level, straps resampled on each enable toggle
    for (int i = 0; i < 5; i++) begin
      tick(1);
      // straps only move together with an enable toggle
      addr_sel <= 3'(i);
      straps <= {7{3'(i)}};
      pulse_enable();
      check(pin_cfg, {7{3'(i)}});
      host_i.start();
      host_i.wbyte({adr_tab[i], 1'b0}, ack_b);
      host_i.stop();
      check(ack_b, 1'b1);
      host_i.start();
      host_i.wbyte({adr_tab[i] ^ 7'h01, 1'b0}, ack_b);
      host_i.stop();
      check(ack_b, 1'b0);
    end
    // locked: data writes dropped, reads give zero
    reg_wr(8'h00, 32'h44332211, 4);
    check(cfg, 64'h0);
    reg_rd(8'h00, 4, rd);
    check(rd, 32'h0);
    reg_wr(OFS_KEY, KEY_OPEN, 1);
    check(lock, 1'b1);
    reg_wr(8'h04, 32'h44332211, 4);
    check(cfg[63:32], 32'h44332211);
    reg_wr(8'h01, 32'h5a, 1);
    check(cfg[15:8], 8'h5a);
    reg_rd(8'h04, 4, rd);
    check(rd, 32'h44332211);
    reg_rd(8'h01, 1, rd);
    check(rd, 32'h5a);
    reg_rd(OFS_KEY, 1, rd);
    check(rd, KEY_OPEN);
    // reset register wipes registers and lock, then reads back zero
    reg_wr(OFS_RST, 32'h1, 1);
    tick(4);
    check({cfg, lock}, 65'h0);
    reg_wr(OFS_KEY, KEY_OPEN, 1);
    reg_rd(OFS_RST, 1, rd);
    check(rd, 32'h0);
    reg_wr(8'h07, 32'hc3, 1);
    check(cfg[63:56], 8'hc3);
    pulse_enable();
    check({cfg, lock}, 65'h0);
    // power saving and termination polling
    tick(1);
    lnk_idle <= 1'b1;
    tick(4);
    check({pwr, chan_en}, {3'h2, 1'b1});
    wait_poll();
    check(term_ind, 1'b0);
    tick(1);
    rx_det <= 1'b1;
    wait_poll();
    check(term_ind, 1'b1);
    tick(1);
    lnk_idle <= 1'b0;
    tick(4);
    check({pwr, term_ind}, {3'h4, 1'b1});
    report_and_stop();
  end
endmodule // tb_rdr_ctl

// *** src/rdr_cfg_sample.sv ***
// module: captures configuration straps and decodes the bus address
`timescale 1ns/100ps
module rdr_cfg_sample
  import rdr_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // sampling request and straps
  input  wire logic                    samp_in,
  input  wire logic [N_PINS*LVL_W-1:0] pins_in,
  input  wire logic [LVL_W-1:0]        addr_pin_in,
  // captured values
  output logic      [N_PINS*LVL_W-1:0] pins_out,
  output logic      [6:0]              dev_adr_out
);
  logic first_q;

  // first cycle after power-on reset, then every enable toggle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      first_q     <= 1'b1;
      pins_out    <= '0;
      dev_adr_out <= ADR_OPEN;
    end else if (first_q || samp_in) begin
      first_q  <= 1'b0;
      pins_out <= pins_in; // [RQ10]
      case (addr_pin_in) // [RQ5]
        LVL_GND:  dev_adr_out <= ADR_SHORT;
        LVL_VDD:  dev_adr_out <= ADR_SHORT;
        LVL_PD:   dev_adr_out <= ADR_PD;
        LVL_PU:   dev_adr_out <= ADR_PU;
        default:  dev_adr_out <= ADR_OPEN;
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  samp_take_a: assert property (samp_in |=> // [RQ10]
    pins_out == $past(pins_in)) else $error("strap not sampled");
endmodule // rdr_cfg_sample

// *** src/rdr_ctl.sv ***
// module: redriver control top, bus target, registers and lock
`timescale 1ns/100ps
// Summary of operation
// RQ1: a read starts with a write carrying one byte, the register offset
// RQ2: then a bus read returns four bytes, least significant byte first
// RQ3: a write carries the offset then four data bytes, low byte first
// RQ4: one-byte and four-byte accesses work; four-byte offsets are aligned
// RQ5: the bus address comes from the five-level address pin
// RQ6: after power-up only the unlock register at 0x40 is writable
// RQ7: writing 0xae to 0x40 opens offsets 0x00 to 0x07 and 0x41
// RQ8: power-on reset clears all state machines and loads register defaults
// RQ9: enable pin high means active, low means deep power saving
// RQ10: the seven strap pins are sampled at power-on and on enable toggle
// RQ11: a rising enable pin acts as a full power-on reset
// RQ12: the system should hold strap and control pins steady
// RQ13: active state carries data, termination indication held asserted
// RQ14: power saving keeps channels on with squelch and detection active
// RQ15: no connection: poll termination, indication deasserted
// RQ16: connected in low-power link state: poll, indication asserted
// RQ17: deep saving floats terminations and drops common-mode level
// RQ18: state is chosen from electrical levels and settings, no decoding
// RQ19: writing one to the reset register resets all; bit self-clears
// RQ20: while locked, writes to other registers are ignored
module rdr_ctl
  import rdr_pkg::*;
(
  // clock and power-on reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // serial bus pins, data is open drain
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_out,
  // control and five-level strap pins
  input  wire logic                    chip_enable_pin_in,
  input  wire logic [LVL_W-1:0]        addr_sel_pin_in,
  input  wire logic [LVL_W-1:0]        chan_a_equalizer_pin_in,
  input  wire logic [LVL_W-1:0]        chan_b_equalizer_pin_in,
  input  wire logic [LVL_W-1:0]        chan_a_deemphasis_pin_in,
  input  wire logic [LVL_W-1:0]        chan_b_deemphasis_pin_in,
  input  wire logic [LVL_W-1:0]        chan_a_swing_pin_in,
  input  wire logic [LVL_W-1:0]        chan_b_swing_pin_in,
  input  wire logic [LVL_W-1:0]        squelch_threshold_pin_in,
  // analog status levels
  input  wire logic                    rx_det_in,
  input  wire logic                    lnk_idle_in,
  // configuration and power outputs
  output logic      [N_CFG*8-1:0]      cfg_regs_out,
  output logic      [N_PINS*LVL_W-1:0] pin_cfg_out,
  output logic                         lock_open_out,
  output logic      [2:0]              pwr_state_out,
  output logic                         chan_en_out,
  output logic                         term_ind_out,
  output logic                         det_en_out,
  output logic                         term_hiz_out,
  output logic                         cm_en_out
);
  rdr_pwr_if   pw ();
  rdr_i2c_st_t st_q;
  logic [7:0]  cfg_q [N_CFG];
  logic [7:0]  key_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic [7:0]  ptr_q;
  logic [7:0]  rd_data;
  logic [6:0]  dev_adr;
  logic [3:0]  cnt_q;
  logic        scl_q;
  logic        sda_q;
  logic        cen_q;
  logic        srst_q;
  logic        rst_pend_q;
  logic        rw_q;
  logic        first_q;
  logic        nack_q;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        wr_stb;
  logic        cen_rise;

  // line edges; inputs already follow this clock
  assign rise  = scl_in && !scl_q;
  assign fall  = !scl_in && scl_q;
  assign start = scl_in && scl_q && sda_q && !sda_in;
  assign stop  = scl_in && scl_q && !sda_q && sda_in;
  assign cen_rise = chip_enable_pin_in && !cen_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cen_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      cen_q <= chip_enable_pin_in;
    end
  end

  // internal reset pulse; the register reset waits for an idle bus
  // so the byte that asked for it is still acknowledged
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= cen_rise                          // [RQ11]
             || (rst_pend_q && st_q == I_IDLE);   // [RQ19]
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // straps are resampled on either enable edge
  rdr_cfg_sample u_samp (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .samp_in     (chip_enable_pin_in ^ cen_q),
    .pins_in     ({squelch_threshold_pin_in, chan_b_swing_pin_in,
                   chan_a_swing_pin_in, chan_b_deemphasis_pin_in,
                   chan_a_deemphasis_pin_in, chan_b_equalizer_pin_in,
                   chan_a_equalizer_pin_in}),
    .addr_pin_in (addr_sel_pin_in),
    .pins_out    (pin_cfg_out),
    .dev_adr_out (dev_adr)
  );

  assign pw.chip_enable_pin      = chip_enable_pin_in;
  assign pw.lnk_idle = lnk_idle_in;
  assign pw.rx_det   = rx_det_in;
  assign pw.srst     = srst_q;

  rdr_pwr_fsm u_pwr (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .pw     (pw.fsm)
  );

  assign pwr_state_out = pw.st;
  assign chan_en_out   = pw.chan_en;
  assign term_ind_out  = pw.term_ind;
  assign det_en_out    = pw.det_en;
  assign term_hiz_out  = pw.term_hiz;
  assign cm_en_out     = pw.cm_en;

  // read view; locked registers other than the key read as zero
  always_comb begin
    rd_data = 8'h00;
    if (ptr_q == OFS_KEY) begin
      rd_data = key_q;
    end else if (lock_open_out && ptr_q <= OFS_CFG_LAST) begin
      rd_data = cfg_q[ptr_q[2:0]];
    end else if (lock_open_out && ptr_q == OFS_RST) begin
      rd_data = {7'h00, rst_pend_q};
    end
  end

  // a data byte (not the offset byte) lands at its eighth bit
  assign wr_stb = (st_q == I_WR) && fall && (cnt_q == BITS_BYTE)
               && !first_q;

  // bus target engine
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q       <= I_IDLE;
      cnt_q      <= '0;
      sh_q       <= '0;
      tx_q       <= '0;
      sda_oe_out <= 1'b0;
      rw_q       <= 1'b0;
      ptr_q      <= '0;
      first_q    <= 1'b0;
      nack_q     <= 1'b0;
    end else if (srst_q || stop) begin
      st_q       <= I_IDLE; // [RQ8] [RQ11]
      sda_oe_out <= 1'b0;
    end else if (start) begin
      st_q       <= I_ADDR;
      cnt_q      <= '0;
      sda_oe_out <= 1'b0;
    end else begin
      case (st_q)
        I_ADDR: begin
          if (rise) begin
            sh_q  <= {sh_q[6:0], sda_in};
            cnt_q <= cnt_q + BIT_STEP;
          end else if (fall && cnt_q == BITS_BYTE) begin
            if (sh_q[7:1] == dev_adr) begin // [RQ5]
              sda_oe_out <= 1'b1;
              rw_q       <= sh_q[0];
              st_q       <= I_ACKA;
            end else begin
              st_q <= I_IDLE;
            end
          end
        end
        I_ACKA: begin
          if (fall && rw_q) begin
            tx_q       <= rd_data; // [RQ2]
            sda_oe_out <= !rd_data[7];
            cnt_q      <= BIT_STEP;
            st_q       <= I_RD;
          end else if (fall) begin
            sda_oe_out <= 1'b0;
            first_q    <= 1'b1; // [RQ1] [RQ3]
            cnt_q      <= '0;
            st_q       <= I_WR;
          end
        end
        I_WR: begin
          if (rise) begin
            sh_q  <= {sh_q[6:0], sda_in};
            cnt_q <= cnt_q + BIT_STEP;
          end else if (fall && cnt_q == BITS_BYTE) begin
            sda_oe_out <= 1'b1;
            first_q    <= 1'b0;
            st_q       <= I_ACKW;
            if (first_q) begin
              ptr_q <= sh_q; // [RQ1] [RQ3]
            end else begin
              ptr_q[1:0] <= ptr_q[1:0] + LANE_STEP; // [RQ4]
            end
          end
        end
        I_ACKW: begin
          if (fall) begin
            sda_oe_out <= 1'b0;
            cnt_q      <= '0;
            st_q       <= I_WR;
          end
        end
        I_RD: begin
          if (fall && cnt_q == BITS_BYTE) begin
            sda_oe_out <= 1'b0;
            ptr_q[1:0] <= ptr_q[1:0] + LANE_STEP; // [RQ2] [RQ4]
            st_q       <= I_RACK;
          end else if (fall) begin
            tx_q       <= {tx_q[6:0], 1'b0};
            sda_oe_out <= !tx_q[6];
            cnt_q      <= cnt_q + BIT_STEP;
          end
        end
        I_RACK: begin
          if (rise) begin
            nack_q <= sda_in;
          end else if (fall && nack_q) begin
            st_q <= I_IDLE;
          end else if (fall) begin
            tx_q       <= rd_data;
            sda_oe_out <= !rd_data[7];
            cnt_q      <= BIT_STEP;
            st_q       <= I_RD;
          end
        end
        default: st_q <= I_IDLE;
      endcase
    end
  end

  // register file with access lock; a wrong key closes the lock again
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < N_CFG; i++) cfg_q[i] <= CFG_RST; // [RQ8]
      key_q         <= KEY_RST;
      lock_open_out <= 1'b0; // [RQ6]
      rst_pend_q    <= 1'b0;
    end else if (srst_q) begin
      for (int i = 0; i < N_CFG; i++) cfg_q[i] <= CFG_RST; // [RQ11]
      key_q         <= KEY_RST;
      lock_open_out <= 1'b0;
      rst_pend_q    <= 1'b0; // [RQ19]
    end else if (wr_stb && ptr_q == OFS_KEY) begin
      key_q         <= sh_q;
      lock_open_out <= (sh_q == KEY_OPEN); // [RQ7]
    end else if (wr_stb && lock_open_out) begin // [RQ20]
      if (ptr_q <= OFS_CFG_LAST) begin
        cfg_q[ptr_q[2:0]] <= sh_q;
      end else if (ptr_q == OFS_RST && sh_q[0]) begin
        rst_pend_q <= 1'b1; // [RQ19]
      end
    end
  end

  // register bytes straight out to the analog settings
  for (genvar g = 0; g < N_CFG; g++) begin : g_cfg
    assign cfg_regs_out[g*8 +: 8] = cfg_q[g];
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  addr_miss_a: assert property ((st_q == I_ADDR && fall && !srst_q // [RQ5]
    && cnt_q == BITS_BYTE && sh_q[7:1] != dev_adr)
    |=> (st_q == I_IDLE && !sda_oe_out)) else $error("foreign address acked");
  addr_hit_a: assert property ((st_q == I_ADDR && fall && !srst_q // [RQ5]
    && cnt_q == BITS_BYTE && sh_q[7:1] == dev_adr)
    |=> (st_q == I_ACKA && sda_oe_out)) else $error("own address not acked");
  cmd_ptr_a: assert property ((st_q == I_WR && first_q && fall // [RQ1]
    && cnt_q == BITS_BYTE && !srst_q) |=> ptr_q == $past(sh_q))
    else $error("offset byte not taken");
  rd_load_a: assert property ((st_q == I_ACKA && fall && rw_q // [RQ2]
    && !srst_q && !stop) |=> (tx_q == $past(rd_data)
    && sda_oe_out == !tx_q[7])) else $error("read byte not loaded");
  lane_step_a: assert property ((st_q == I_RD && fall && !srst_q // [RQ4]
    && cnt_q == BITS_BYTE) |=> (ptr_q[7:2] == $past(ptr_q[7:2])
    && ptr_q[1:0] == $past(ptr_q[1:0]) + LANE_STEP))
    else $error("byte lane not advanced");
  lock_keep_a: assert property ((wr_stb && !lock_open_out // [RQ20]
    && ptr_q != OFS_KEY && !srst_q) |=> ($stable(cfg_regs_out)
    && !rst_pend_q)) else $error("locked register written");
  key_open_a: assert property ((wr_stb && ptr_q == OFS_KEY // [RQ7]
    && sh_q == KEY_OPEN && !srst_q) |=> lock_open_out)
    else $error("key did not open lock");
  cen_reset_a: assert property (cen_rise |=> srst_q // [RQ11]
    ##1 (!lock_open_out && cfg_regs_out == {N_CFG{CFG_RST}}))
    else $error("enable rise did not reset");
  self_clr_a: assert property ((rst_pend_q && st_q == I_IDLE) // [RQ19]
    |=> srst_q ##1 !rst_pend_q) else $error("reset bit not cleared");

  rd_cov: cover property (st_q == I_RACK ##1 st_q == I_RD);
  wr_cov: cover property (wr_stb && lock_open_out && ptr_q <= OFS_CFG_LAST);
  unlock_cov: cover property (!lock_open_out ##1 lock_open_out);
endmodule // rdr_ctl

// *** src/rdr_pkg.sv ***
// package: constants and types of the redriver control block
package rdr_pkg;
  localparam int CLK_MHZ  = 40;
  localparam int POLL_US  = 100;
  localparam int POLL_CYC = POLL_US * CLK_MHZ;
  localparam int POLL_W   = 12;
  localparam int N_CFG    = 8;
  localparam int N_PINS   = 7;
  localparam int LVL_W    = 3;
  localparam logic [7:0] OFS_CFG_LAST = 8'h07;
  localparam logic [7:0] OFS_KEY      = 8'h40;
  localparam logic [7:0] OFS_RST      = 8'h41;
  localparam logic [7:0] KEY_OPEN     = 8'hae;
  localparam logic [7:0] KEY_RST      = 8'h00;
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [2:0] LVL_GND  = 3'h0;
  localparam logic [2:0] LVL_PD   = 3'h1;
  localparam logic [2:0] LVL_OPEN = 3'h2;
  localparam logic [2:0] LVL_PU   = 3'h3;
  localparam logic [2:0] LVL_VDD  = 3'h4;
  localparam logic [6:0] ADR_SHORT = 7'h12;
  localparam logic [6:0] ADR_PD    = 7'h16;
  localparam logic [6:0] ADR_PU    = 7'h1e;
  localparam logic [6:0] ADR_OPEN  = 7'h1a;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_STEP  = 4'h1;
  localparam logic [1:0] LANE_STEP = 2'h1;
  typedef enum logic [6:0] {
    I_IDLE = 7'h01, I_ADDR = 7'h02, I_ACKA = 7'h04, I_WR = 7'h08,
    I_ACKW = 7'h10, I_RD = 7'h20, I_RACK = 7'h40
  } rdr_i2c_st_t;
  typedef enum logic [2:0] {
    P_DEEP = 3'h1, P_SAVE = 3'h2, P_ACT = 3'h4
  } rdr_pwr_st_t;
endpackage

// *** src/rdr_pwr_fsm.sv ***
// module: active, power-saving and deep power-saving state machine
`timescale 1ns/100ps
module rdr_pwr_fsm
  import rdr_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // control and status
  rdr_pwr_if.fsm    pw
);
  logic [POLL_W-1:0] poll_q;
  logic              tick;

  // periodic termination poll enable, only runs while saving power
  assign tick = (poll_q == POLL_W'(POLL_CYC - 1));
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      poll_q <= '0;
    end else if (pw.st != P_SAVE || tick) begin
      poll_q <= '0;
    end else begin
      poll_q <= poll_q + POLL_W'(1);
    end
  end

  // state choice uses pin, squelch and detection levels plus the internal reset pulse [RQ18]
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pw.st <= P_DEEP;
    end else if (pw.srst || !pw.chip_enable_pin) begin
      pw.st <= P_DEEP; // [RQ9]
    end else begin
      case (pw.st)
        P_DEEP:  pw.st <= P_ACT; // [RQ9]
        P_ACT:   if (pw.lnk_idle) pw.st <= P_SAVE;
        P_SAVE:  if (pw.term_ind && !pw.lnk_idle) pw.st <= P_ACT;
        default: pw.st <= P_DEEP;
      endcase
    end
  end

  // outputs follow the state one cycle later
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pw.term_ind <= 1'b0;
      pw.det_en   <= 1'b0;
      pw.chan_en  <= 1'b0;
      pw.term_hiz <= 1'b1;
      pw.cm_en    <= 1'b0;
    end else begin
      pw.chan_en  <= (pw.st != P_DEEP);            // [RQ14]
      pw.term_hiz <= (pw.st == P_DEEP);            // [RQ17]
      pw.cm_en    <= (pw.st != P_DEEP);            // [RQ17]
      pw.det_en   <= (pw.st == P_SAVE) && tick;    // [RQ15] [RQ16]
      if (pw.srst || pw.st == P_DEEP) begin
        pw.term_ind <= 1'b0;
      end else if (pw.st == P_ACT) begin
        pw.term_ind <= 1'b1;                       // [RQ13]
      end else if (tick) begin
        pw.term_ind <= pw.rx_det;                  // [RQ15] [RQ16]
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  deep_off_a: assert property (!pw.chip_enable_pin |=> pw.st == P_DEEP // [RQ17]
    ##1 (pw.term_hiz && !pw.cm_en)) else $error("deep state not kept");
  act_ind_a: assert property ((pw.st == P_ACT && !pw.srst) |=> // [RQ13]
    (pw.term_ind && !pw.det_en)) else $error("active indication lost");
  poll_ind_a: assert property ((pw.st == P_SAVE && tick && !pw.srst) // [RQ15]
    |=> (pw.det_en && pw.term_ind == $past(pw.rx_det)))
    else $error("poll result not shown");
  save_cov: cover property (pw.st == P_SAVE ##1 pw.st == P_ACT);
endmodule // rdr_pwr_fsm

// *** src/rdr_pwr_if.sv ***
// interface: power-state control between control core and state machine
`timescale 1ns/100ps
interface rdr_pwr_if;
  import rdr_pkg::*;
  logic        chip_enable_pin;
  logic        lnk_idle;
  logic        rx_det;
  logic        srst;
  rdr_pwr_st_t st;
  logic        term_ind;
  logic        det_en;
  logic        chan_en;
  logic        term_hiz;
  logic        cm_en;
  modport ctl (output chip_enable_pin, lnk_idle, rx_det, srst,
               input st, term_ind, det_en, chan_en, term_hiz, cm_en);
  modport fsm (input chip_enable_pin, lnk_idle, rx_det, srst,
               output st, term_ind, det_en, chan_en, term_hiz, cm_en);
endinterface
